// ---- hw/mcr_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// stored configuration handed from the register bank to the pin logic
interface mcr_cfg_if;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] cfg_c;
    modport bank (output cfg_a, output cfg_b, output cfg_c);
    modport user (input cfg_a, input cfg_b, input cfg_c);
endinterface
`default_nettype wire

// ---- hw/mcr_config_regs.sv ----
// Notes on behaviour
// - bit7 picks dropout source: alarm or pin
// - bit6 masks supply-low alarm on fault output
// - bit5 inverts dropout output
// - bit4 picks programmed address else A2h
// - bit3 moves alarm-enable row between tables
// - bit2 inverts rate-select output
// - bit1 sources driver rate bit from pin
// - bit0 inverts transmit-fault input
// - disable input raises fault output when enabled
// - alarm flags latch when enabled
// - quick-trip flags latch when enabled
// - warning flags latch when enabled
// - crossover enable for monitor-three conversions
// - monitor-two reference ground or supply
// - disable clears monitor three/four flags
// - fet-gate fault ORed into disable output
// - fault pin ORed into disable output
// - disable input ORed unless ignored
// - monitor-three range: auto, fine, coarse
`timescale 1ns/1ps
`default_nettype none
module mcr_config_regs (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // register port from the two-wire host logic
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    // password state
    input  wire logic        level_one_password,
    input  wire logic        level_two_password,
    input  wire logic        table_write_permission,
    // programmed device address
    input  wire logic [7:0]  device_address,
    // pins and internal signals
    input  wire logic        rx_dropout_input,
    input  wire logic        rx_dropout_low_alarm,
    input  wire logic        tx_fault_input,
    input  wire logic        tx_disable_input,
    input  wire logic        internal_fet_gate_fault,
    input  wire logic        supply_low_alarm,
    input  wire logic        supply_above_pod,
    input  wire logic        rate_select_source,
    input  wire logic        user_rate_bit,
    // monitor flag comparisons, one update strobe per conversion
    input  wire logic        flag_update,
    input  wire logic [15:0] alarm_compare,
    input  wire logic [15:0] quick_trip_compare,
    input  wire logic [15:0] warning_compare,
    input  wire logic [15:0] mon34_flag_mask,
    // outputs
    output logic             rx_dropout_output,
    output logic             tx_fault_output,
    output logic             tx_disable_output,
    output logic             rate_select_output,
    output logic             driver_rate_bit,
    output logic [7:0]       slave_address,
    output logic             alarm_row_in_upper_table,
    output logic             crossover_enable,
    output logic             monitor_two_supply_reference,
    output logic [1:0]       range_mode,
    output logic [15:0]      alarm_flags,
    output logic [15:0]      quick_trip_flags,
    output logic [15:0]      warning_flags
);
    mcr_cfg_if cfg ();

    logic [7:0]  cfg_a_ff;
    logic [7:0]  cfg_b_ff;
    logic [7:0]  cfg_c_ff;
    logic        wr_allowed;
    logic        fault_in;
    logic        dropout_src;
    logic        pod_seen_ff;
    logic [15:0] clear_mask;
    logic [15:0] alarm_w;
    logic [15:0] quick_w;
    logic [15:0] warn_w;
    mcr_pkg::mcr_range_e range_e;

    // all checks below run on mclk and rest while reset is low
    default clocking cfg_cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // write permission check
    assign wr_allowed = level_two_password
                      | (level_one_password & table_write_permission);

    // configuration storage; ignored writes leave state untouched
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_a_ff <= mcr_pkg::PIN_AND_ADDRESS_CONFIG_RST;
            cfg_b_ff <= mcr_pkg::FLAG_LATCH_CONFIG_RST;
            cfg_c_ff <= mcr_pkg::DISABLE_AND_RSSI_CONFIG_RST;
        end else if (clk_en && reg_wr && wr_allowed) begin
            case (reg_addr)
                mcr_pkg::PIN_AND_ADDRESS_CONFIG_OFS: begin
                    cfg_a_ff <= reg_wdata;
                end
                mcr_pkg::FLAG_LATCH_CONFIG_OFS: begin
                    cfg_b_ff <= reg_wdata & mcr_pkg::FLAG_LATCH_CONFIG_WMASK;
                end
                mcr_pkg::DISABLE_AND_RSSI_CONFIG_OFS: begin
                    cfg_c_ff <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    assign cfg.cfg_a = cfg_a_ff;
    assign cfg.cfg_b = cfg_b_ff;
    assign cfg.cfg_c = cfg_c_ff;

    // read port, registered; unmapped offsets answer zero with no hit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else if (clk_en) begin
            reg_hit   <= 1'b0;
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    mcr_pkg::PIN_AND_ADDRESS_CONFIG_OFS: begin
                        reg_rdata <= cfg.cfg_a;
                        reg_hit   <= 1'b1;
                    end
                    mcr_pkg::FLAG_LATCH_CONFIG_OFS: begin
                        reg_rdata <= cfg.cfg_b;
                        reg_hit   <= 1'b1;
                    end
                    mcr_pkg::DISABLE_AND_RSSI_CONFIG_OFS: begin
                        reg_rdata <= cfg.cfg_c;
                        reg_hit   <= 1'b1;
                    end
                    default: begin
                        reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // combinational sources from the stored configuration
    assign fault_in = tx_fault_input
                    ^ cfg.cfg_a[mcr_pkg::FAULT_INPUT_INVERT_BIT];
    assign dropout_src = cfg.cfg_a[mcr_pkg::DROPOUT_SOURCE_SELECT_BIT]
                       ? rx_dropout_input : rx_dropout_low_alarm;

    // power-on: remember once supply crossed the power-on threshold
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pod_seen_ff <= 1'b0;
        end else if (clk_en && supply_above_pod) begin
            pod_seen_ff <= 1'b1;
        end
    end

    // pin outputs; config takes effect on the next edge after the write
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_dropout_output  <= 1'b0;
            tx_fault_output    <= 1'b1;
            tx_disable_output  <= 1'b0;
            rate_select_output <= 1'b0;
            driver_rate_bit    <= 1'b0;
        end else if (clk_en) begin
            rx_dropout_output <= dropout_src
                ^ cfg.cfg_a[mcr_pkg::DROPOUT_OUTPUT_INVERT_BIT];
            // masked: output held low until above threshold, supply-low alarm never shown
            if (cfg.cfg_a[mcr_pkg::SUPPLY_LOW_POWERUP_MASK_BIT]) begin
                tx_fault_output <= ~pod_seen_ff ? 1'b0
                    : (fault_in | (tx_disable_input
                    & cfg.cfg_b[mcr_pkg::FAULT_FOLLOWS_DISABLE_BIT]));
            end else begin
                tx_fault_output <= ~pod_seen_ff | supply_low_alarm | fault_in
                    | (tx_disable_input
                    & cfg.cfg_b[mcr_pkg::FAULT_FOLLOWS_DISABLE_BIT]);
            end
            tx_disable_output <=
                (internal_fet_gate_fault
                 & cfg.cfg_c[mcr_pkg::FET_GATE_TO_DISABLE_BIT])
              | (fault_in
                 & cfg.cfg_c[mcr_pkg::FAULT_PIN_TO_DISABLE_BIT])
              | (tx_disable_input
                 & ~cfg.cfg_c[mcr_pkg::DISABLE_INPUT_IGNORE_BIT]);
            rate_select_output <= rate_select_source
                ^ cfg.cfg_a[mcr_pkg::RATE_SELECT_OUTPUT_INVERT_BIT];
            // pin polarity follows the output as driven next
            driver_rate_bit <= cfg.cfg_a[mcr_pkg::RATE_BIT_FROM_PIN_BIT]
                ? (rate_select_source
                   ^ cfg.cfg_a[mcr_pkg::RATE_SELECT_OUTPUT_INVERT_BIT])
                : user_rate_bit;
        end
    end

    // monitor-three range decode: both force bits act as normal
    always_comb begin
        case (cfg.cfg_c[1:0])
            2'b01: begin
                range_e = mcr_pkg::MCR_RANGE_FINE;
            end
            2'b10: begin
                range_e = mcr_pkg::MCR_RANGE_COARSE;
            end
            default: begin
                range_e = mcr_pkg::MCR_RANGE_AUTO;
            end
        endcase
    end

    // configuration-driven control outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            slave_address                <= mcr_pkg::DEFAULT_SLAVE_ADDRESS;
            alarm_row_in_upper_table     <= 1'b0;
            crossover_enable             <= 1'b0;
            monitor_two_supply_reference <= 1'b0;
            range_mode                   <= 2'b00;
        end else if (clk_en) begin
            slave_address <= cfg.cfg_a[mcr_pkg::SLAVE_ADDRESS_SELECT_BIT]
                ? device_address : mcr_pkg::DEFAULT_SLAVE_ADDRESS;
            alarm_row_in_upper_table <=
                cfg.cfg_a[mcr_pkg::ALARM_ROW_LOCATION_BIT];
            crossover_enable <=
                cfg.cfg_c[mcr_pkg::CROSSOVER_ENABLE_BIT];
            monitor_two_supply_reference <=
                cfg.cfg_c[mcr_pkg::MONITOR_TWO_SUPPLY_REF_BIT];
            range_mode <= range_e;
        end
    end

    // disable event wipes monitor three/four flags while it is high
    assign clear_mask = (tx_disable_input
        & cfg.cfg_c[mcr_pkg::DISABLE_CLEARS_MON34_BIT])
        ? mon34_flag_mask : 16'h0000;

    mcr_flag_latch u_alarm (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .update     (flag_update),
        .latch_en   (cfg.cfg_b[mcr_pkg::ALARM_FLAG_LATCH_BIT]),
        .clear_mask (clear_mask),
        .compare    (alarm_compare),
        .flags      (alarm_w)
    );

    mcr_flag_latch u_quick (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .update     (flag_update),
        .latch_en   (cfg.cfg_b[mcr_pkg::QUICK_TRIP_FLAG_LATCH_BIT]),
        .clear_mask (clear_mask),
        .compare    (quick_trip_compare),
        .flags      (quick_w)
    );

    mcr_flag_latch u_warn (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .update     (flag_update),
        .latch_en   (cfg.cfg_b[mcr_pkg::WARNING_FLAG_LATCH_BIT]),
        .clear_mask (clear_mask),
        .compare    (warning_compare),
        .flags      (warn_w)
    );

    assign alarm_flags      = alarm_w;
    assign quick_trip_flags = quick_w;
    assign warning_flags    = warn_w;

    // checks
    AST_WRITE_BLOCKED: assert property (
        (clk_en && reg_wr && !wr_allowed) |=> $stable(cfg_a_ff)
            && $stable(cfg_b_ff) && $stable(cfg_c_ff))
        else $error("config changed on refused write");
    AST_ADDR_SEL: assert property (
        (clk_en && !cfg_a_ff[mcr_pkg::SLAVE_ADDRESS_SELECT_BIT])
            |=> slave_address == mcr_pkg::DEFAULT_SLAVE_ADDRESS)
        else $error("slave address not fixed default");
    AST_DROPOUT: assert property (
        clk_en |=> rx_dropout_output == ($past(dropout_src)
            ^ $past(cfg_a_ff[mcr_pkg::DROPOUT_OUTPUT_INVERT_BIT])))
        else $error("dropout output wrong");
    AST_DROP_SRC: assert property (
        (clk_en && !cfg_a_ff[7] && !cfg_a_ff[5]) |=>
            rx_dropout_output == $past(rx_dropout_low_alarm))
        else $error("dropout source wrong");
    AST_DISABLE_OR: assert property (
        (clk_en && tx_disable_input && !cfg_c_ff[2]) |=> tx_disable_output)
        else $error("disable input not passed");
    AST_FET_OFF: assert property (
        (clk_en && !tx_disable_input && !cfg_c_ff[3] && !cfg_c_ff[4])
            |=> !tx_disable_output)
        else $error("disable output raised without source");
    AST_FAULT_PIN: assert property (
        (clk_en && fault_in && cfg_c_ff[3]) |=> tx_disable_output)
        else $error("fault pin not passed to disable output");
    AST_FAULT_DIS: assert property (
        (clk_en && pod_seen_ff && tx_disable_input && cfg_b_ff[5])
            |=> tx_fault_output)
        else $error("fault output did not follow disable");
    AST_MASK_PWR: assert property (
        (clk_en && !pod_seen_ff && cfg_a_ff[6]) |=> !tx_fault_output)
        else $error("masked fault output not low");
    AST_RATE_INV: assert property (
        clk_en |=> rate_select_output == ($past(rate_select_source)
            ^ $past(cfg_a_ff[mcr_pkg::RATE_SELECT_OUTPUT_INVERT_BIT])))
        else $error("rate select output wrong");
    AST_LATCH_HOLD: assert property (
        (clk_en && cfg_b_ff[2] && clear_mask == 16'h0000)
            |=> (alarm_flags & $past(alarm_flags)) == $past(alarm_flags))
        else $error("latched alarm flag dropped");
    AST_RANGE: assert property (
        (clk_en && cfg_c_ff[1:0] == 2'b11) |=> range_mode == 2'b00)
        else $error("range mode not normal");

    // a permitted write lands at once, then reaches the outputs next edge
    sequence s_cfg_a_write;
        clk_en && reg_wr && wr_allowed
            && reg_addr == mcr_pkg::PIN_AND_ADDRESS_CONFIG_OFS;
    endsequence
    sequence s_write_then_update;
        s_cfg_a_write ##1 (clk_en && !reg_wr);
    endsequence
    AST_CFG_LANDS: assert property (
        s_cfg_a_write |=> cfg_a_ff == $past(reg_wdata))
        else $error("permitted write did not land");
    AST_NEXT_UPDATE: assert property (
        s_write_then_update |=> alarm_row_in_upper_table
            == $past(reg_wdata[mcr_pkg::ALARM_ROW_LOCATION_BIT], 2))
        else $error("new setting not applied on next update");
endmodule
`default_nettype wire

// ---- hw/mcr_flag_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
// one flag group: latching or tracking, with optional forced clear
module mcr_flag_latch (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // control
    input  wire logic              update,
    input  wire logic              latch_en,
    input  wire logic [15:0]       clear_mask,
    // data
    input  wire logic [15:0]       compare,
    output logic      [15:0]       flags
);
    logic [15:0] flags_ff;
    logic [15:0] nxt_flags;

    // new comparison sets bits; latched bits only leave via clear mask
    always_comb begin
        nxt_flags = flags_ff;
        if (update) begin
            if (latch_en) begin
                nxt_flags = flags_ff | compare;
            end else begin
                nxt_flags = compare;
            end
        end
        nxt_flags = nxt_flags & ~(clear_mask & ~(update ? compare : 16'h0000));
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags_ff <= 16'h0000;
        end else if (clk_en) begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule
`default_nettype wire

// ---- hw/mcr_pkg.sv ----
package mcr_pkg;
    // register offsets in the configuration table
    localparam logic [7:0] PIN_AND_ADDRESS_CONFIG_OFS  = 8'h89;
    localparam logic [7:0] FLAG_LATCH_CONFIG_OFS       = 8'h8a;
    localparam logic [7:0] DISABLE_AND_RSSI_CONFIG_OFS = 8'h8b;
    // reset values
    localparam logic [7:0] PIN_AND_ADDRESS_CONFIG_RST  = 8'h80;
    localparam logic [7:0] FLAG_LATCH_CONFIG_RST       = 8'h00;
    localparam logic [7:0] DISABLE_AND_RSSI_CONFIG_RST = 8'h00;
    // writable bits of the flag latch register, reserved read zero
    localparam logic [7:0] FLAG_LATCH_CONFIG_WMASK     = 8'h27;
    // first register fields
    localparam int DROPOUT_SOURCE_SELECT_BIT     = 7;
    localparam int SUPPLY_LOW_POWERUP_MASK_BIT   = 6;
    localparam int DROPOUT_OUTPUT_INVERT_BIT     = 5;
    localparam int SLAVE_ADDRESS_SELECT_BIT      = 4;
    localparam int ALARM_ROW_LOCATION_BIT        = 3;
    localparam int RATE_SELECT_OUTPUT_INVERT_BIT = 2;
    localparam int RATE_BIT_FROM_PIN_BIT         = 1;
    localparam int FAULT_INPUT_INVERT_BIT        = 0;
    // second register fields
    localparam int FAULT_FOLLOWS_DISABLE_BIT     = 5;
    localparam int ALARM_FLAG_LATCH_BIT          = 2;
    localparam int QUICK_TRIP_FLAG_LATCH_BIT     = 1;
    localparam int WARNING_FLAG_LATCH_BIT        = 0;
    // third register fields
    localparam int CROSSOVER_ENABLE_BIT          = 7;
    localparam int MONITOR_TWO_SUPPLY_REF_BIT    = 6;
    localparam int DISABLE_CLEARS_MON34_BIT      = 5;
    localparam int FET_GATE_TO_DISABLE_BIT       = 4;
    localparam int FAULT_PIN_TO_DISABLE_BIT      = 3;
    localparam int DISABLE_INPUT_IGNORE_BIT      = 2;
    localparam int FORCE_COARSE_RANGE_BIT        = 1;
    localparam int FORCE_FINE_RANGE_BIT          = 0;
    // fixed slave address when no programmed address is chosen
    localparam logic [7:0] DEFAULT_SLAVE_ADDRESS = 8'ha2;
    // flag row width (two bytes per flag group)
    localparam int FLAG_W = 16;
    // monitor-three conversion modes
    typedef enum logic [1:0] {
        MCR_RANGE_AUTO,
        MCR_RANGE_FINE,
        MCR_RANGE_COARSE
    } mcr_range_e;
endpackage

// ---- tb/mcr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-wire host side: one register access at a time, off the falling edge
module mcr_host_model (
    // clock
    input  wire logic       mclk,
    // register port toward the bank
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_hit,
    // password state held by the host
    output logic            level_one_password,
    output logic            level_two_password,
    output logic            table_write_permission
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        {level_two_password, level_one_password} = 2'b00;
        table_write_permission = 1'b0;
    end

    // level is {pw2, pw1, perm}; a legal host holds pw2 or pw1 with perm
    task automatic wr(input logic [7:0] addr, input logic [7:0] data,
                      input logic [2:0] lvl);
        @(negedge mclk);
        {level_two_password, level_one_password,
         table_write_permission} = lvl;
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(negedge mclk);
        // released lines must not keep showing the last value
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask

    // read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic hit);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = addr;
        @(negedge mclk);
        data = reg_rdata;
        hit = reg_hit;
        reg_rd = 1'b0;
        reg_addr = ~addr;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_module_config_registers.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_module_config_registers;
    // clock, reset and pins
    logic mclk, reset_n, clk_en, reg_wr, reg_rd, reg_hit;
    logic level_one_password, level_two_password, table_write_permission;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, device_address, slave_address;
    logic rx_dropout_input, rx_dropout_low_alarm, tx_fault_input;
    logic tx_disable_input, internal_fet_gate_fault, supply_low_alarm;
    logic supply_above_pod, rate_select_source, user_rate_bit, flag_update;
    logic [15:0] alarm_compare, quick_trip_compare, warning_compare;
    logic [15:0] mon34_flag_mask, alarm_flags, quick_trip_flags, warning_flags;
    logic rx_dropout_output, tx_fault_output, tx_disable_output;
    logic rate_select_output, driver_rate_bit, alarm_row_in_upper_table;
    logic crossover_enable, monitor_two_supply_reference;
    logic [1:0] range_mode;
    // reference state mirrored from the driven inputs
    logic [7:0] ra, rb, rc;
    logic pod;
    logic [15:0] ea, eq, ew;
    logic [31:0] seed, r;
    int fail_count, n_compared, cyc;

    mcr_config_regs uut (.mclk, .reset_n, .clk_en, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .level_one_password,
        .level_two_password, .table_write_permission, .device_address,
        .rx_dropout_input, .rx_dropout_low_alarm, .tx_fault_input,
        .tx_disable_input, .internal_fet_gate_fault, .supply_low_alarm,
        .supply_above_pod, .rate_select_source, .user_rate_bit,
        .flag_update, .alarm_compare, .quick_trip_compare, .warning_compare,
        .mon34_flag_mask, .rx_dropout_output, .tx_fault_output,
        .tx_disable_output, .rate_select_output, .driver_rate_bit,
        .slave_address, .alarm_row_in_upper_table, .crossover_enable,
        .monitor_two_supply_reference, .range_mode, .alarm_flags,
        .quick_trip_flags, .warning_flags);

    mcr_host_model host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_hit, .level_one_password, .level_two_password,
        .table_write_permission);

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // next flag value: latch or replace, forced clear loses to a new set
    function automatic logic [15:0] nxt_flag(input logic [15:0] f,
                                             input logic [15:0] cmp,
                                             input logic lat);
        logic [15:0] b;
        b = flag_update ? (lat ? (f | cmp) : cmp) : f;
        if (tx_disable_input && rc[5])
            b = (b & ~mon34_flag_mask)
                | (flag_update ? (cmp & mon34_flag_mask) : 16'h0000);
        return b;
    endfunction

    // reference copy of the bank, frozen when clk_en is low
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ra <= 8'h80;
            rb <= 8'h00;
            rc <= 8'h00;
            pod <= 1'b0;
            ea <= 16'h0000;
            eq <= 16'h0000;
            ew <= 16'h0000;
        end else if (clk_en) begin
            if (reg_wr && (level_two_password ||
                (level_one_password && table_write_permission))) begin
                case (reg_addr)
                    8'h89: ra <= reg_wdata;
                    8'h8a: rb <= reg_wdata & 8'h27;
                    8'h8b: rc <= reg_wdata;
                    default: ;
                endcase
            end
            if (supply_above_pod)
                pod <= 1'b1;
            ea <= nxt_flag(ea, alarm_compare, rb[2]);
            eq <= nxt_flag(eq, quick_trip_compare, rb[1]);
            ew <= nxt_flag(ew, warning_compare, rb[0]);
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic exp_txf();
        logic flt;
        flt = (tx_fault_input ^ ra[0]) | (tx_disable_input & rb[5]);
        if (ra[6])
            return pod & flt;
        return !pod | supply_low_alarm | flt;
    endfunction

    // all pin and field outputs against the mirrored configuration
    task automatic check_outputs();
        logic src, dis;
        src = ra[7] ? rx_dropout_input : rx_dropout_low_alarm;
        dis = (rc[4] & internal_fet_gate_fault)
            | (rc[3] & (tx_fault_input ^ ra[0]));
        dis = dis | (!rc[2] & tx_disable_input);
        check(rx_dropout_output, src ^ ra[5]);
        check(tx_fault_output, exp_txf());
        check(tx_disable_output, dis);
        check(rate_select_output, rate_select_source ^ ra[2]);
        check(driver_rate_bit, ra[1] ? rate_select_source ^ ra[2]
                               : user_rate_bit);
        check(slave_address, ra[4] ? device_address : 8'ha2);
        check(alarm_row_in_upper_table, ra[3]);
        check(crossover_enable, rc[7]);
        check(monitor_two_supply_reference, rc[6]);
        check(range_mode, rc[1:0] == 2'b01 ? 2'd1 :
                          rc[1:0] == 2'b10 ? 2'd2 : 2'd0);
        check(alarm_flags, ea);
        check(quick_trip_flags, eq);
        check(warning_flags, ew);
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        logic [7:0] d;
        logic h;
        seed = 32'hbcd1e0dc;
        {fail_count, n_compared, cyc} = '0;
        {reset_n, clk_en, flag_update, device_address} = 11'h000;
        {rx_dropout_input, rx_dropout_low_alarm, tx_fault_input} = 3'b000;
        {tx_disable_input, internal_fet_gate_fault, supply_low_alarm} = 3'b000;
        {supply_above_pod, rate_select_source, user_rate_bit} = 3'b000;
        {alarm_compare, quick_trip_compare} = 32'h0000_0000;
        {warning_compare, mon34_flag_mask} = 32'h0000_0000;
        clk_en = 1'b1;
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        // reset values, then one unmapped offset
        for (int i = 0; i < 4; i++) begin
            host.rd(8'h89 + 8'(i), d, h);
            check(d, i == 0 ? 8'h80 : 8'h00);
            check(h, i < 3);
        end
        check_outputs();
        // reserved bits of the flag latch register read zero
        host.wr(8'h8a, 8'hff, 3'b100);
        host.rd(8'h8a, d, h);
        check(d, 8'h27);
        // no access, level one alone, then level one with permission
        for (int j = 0; j < 3; j++) begin
            host.wr(8'h8b, 8'hff, {1'b0, j != 0, j == 2});
            host.rd(8'h8b, d, h);
            check(d, j == 2 ? 8'hff : 8'h00);
        end
        // a write while clk_en is low must not land
        @(negedge mclk);
        clk_en = 1'b0;
        host.wr(8'h8b, 8'h00, 3'b100);
        @(negedge mclk);
        clk_en = 1'b1;
        host.rd(8'h8b, d, h);
        check(d, 8'hff);
        // masked supply alarm before the supply threshold is seen
        host.wr(8'h89, 8'hc0, 3'b100);
        repeat (2) @(negedge mclk);
        check_outputs();
        // random configurations with writes two cycles apart and a flag update
        for (int k = 0; k < 250; k++) begin
            r = $random(seed);
            host.wr(8'h89, r[7:0], 3'b100);
            host.wr(8'h8a, r[15:8], 3'b100);
            host.wr(8'h8b, r[23:16], 3'b100);
            @(negedge mclk);
            r = $random(seed);
            {rx_dropout_input, rx_dropout_low_alarm, tx_fault_input} = r[2:0];
            {tx_disable_input, internal_fet_gate_fault} = r[4:3];
            {supply_low_alarm, supply_above_pod, rate_select_source} = r[7:5];
            {user_rate_bit, device_address} = r[16:8];
            r = $random(seed);
            {alarm_compare, quick_trip_compare} = r;
            r = $random(seed);
            {warning_compare, mon34_flag_mask} = r;
            flag_update = 1'b1;
            @(negedge mclk);
            flag_update = 1'b0;
            @(negedge mclk);
            check_outputs();
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
